// ===== common/tsd_pkg.sv
// Constants and types for the trim and swap delay register bank.
// Assumes a 32-bit APB register bus with byte addresses four times the index.
package tsd_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Bus geometry
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_TRIM_A = 8'h7E;
   localparam logic [7:0] IDX_TRIM_B = 8'h7F;
   localparam logic [7:0] IDX_TRIM_C = 8'h80;
   localparam logic [7:0] IDX_TRIM_D = 8'h81;
   localparam logic [7:0] IDX_OVL_DLY = 8'h9A;
   localparam logic [7:0] IDX_STEER_DLY = 8'h9B;
   localparam logic [7:0] IDX_STATUS = 8'hA0;

   ////////////////////////////////////////////////////////////////////////
   // Field widths and reset values
   localparam int unsigned NUM_CH = 4;
   localparam int unsigned TRIM_W = 8;
   localparam int unsigned DLY_W = 5;
   localparam int unsigned CNT_W = 7;
   localparam logic [7:0] TRIM_RESET = 8'h00;
   localparam logic [4:0] OVL_RESET = 5'h08;
   localparam logic [4:0] STEER_RESET = 5'h07;

   // Fixed part of the overlap, in converter clock cycles
   localparam logic [6:0] OVL_BASE_CYC = 7'h04;

   // Status register bit positions
   localparam int unsigned ST_OVERLAP = 0;
   localparam int unsigned ST_STEER = 1;
   localparam int unsigned ST_BUSY = 2;
   localparam int unsigned ST_CAL_WR = 3;
   localparam int unsigned ST_FUSE_PEND = 4;

   // Swap sequencer states
   typedef enum logic {TSD_IDLE, TSD_OVERLAP} tsd_swap_e;

endpackage : tsd_pkg

// ===== common/tsd_swap_if.sv
// Link between the register bank and its swap sequencer.
// Assumes both ends run on the same converter clock.
`timescale 1ns/100ps
interface tsd_swap_if;
   logic swap_start;
   logic [4:0] ovl_dly;
   logic [4:0] steer_dly;
   logic overlap_active;
   logic steer_sel;
   logic busy;

   modport ctrl (
      output swap_start,
      output ovl_dly,
      output steer_dly,
      input overlap_active,
      input steer_sel,
      input busy
   );

   modport timer (
      input swap_start,
      input ovl_dly,
      input steer_dly,
      output overlap_active,
      output steer_sel,
      output busy
   );
endinterface : tsd_swap_if

// ===== logic/tsd_swap_timer.sv
// Background core swap sequencer: overlap window and delayed steering select.
// Assumes swap requests and delays come from logic on the same clock.
`timescale 1ns/100ps
module tsd_swap_timer
   import tsd_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   tsd_swap_if.timer sw
);

   tsd_swap_e state;
   tsd_swap_e next_state;
   logic [6:0] ovl_cnt;
   logic [6:0] next_ovl_cnt;
   logic [6:0] ovl_len;
   logic [6:0] next_ovl_len;
   logic steer_pend;
   logic next_steer_pend;
   logic [4:0] steer_cnt;
   logic [4:0] next_steer_cnt;
   logic steer_sel;
   logic next_steer_sel;
   logic start_ok;
   logic [6:0] run_cnt;

   // A new swap only starts once the previous one has fully finished
   assign start_ok = sw.swap_start && (state == TSD_IDLE) && !steer_pend;

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic for the overlap window and steering delay
   always_comb
   begin
      next_state = state;
      next_ovl_cnt = ovl_cnt;
      next_ovl_len = ovl_len;
      next_steer_pend = steer_pend;
      next_steer_cnt = steer_cnt;
      next_steer_sel = steer_sel;
      case (state)
         TSD_IDLE:
         begin
            if (start_ok)
            begin
               // Delays sampled here, so late writes cannot cut a swap
               next_ovl_len = 7'(OVL_BASE_CYC
                  + {1'b0, sw.ovl_dly, 1'b0});
               next_ovl_cnt = 7'(next_ovl_len - 7'h01);
               next_state = TSD_OVERLAP;
            end
         end
         TSD_OVERLAP:
         begin
            if (ovl_cnt == 7'h00)
               next_state = TSD_IDLE;
            else
               next_ovl_cnt = 7'(ovl_cnt - 7'h01);
         end
         default:
            next_state = TSD_IDLE;
      endcase
      // Steering select moves only as part of a swap
      if (start_ok)
      begin
         next_steer_pend = 1'b1;
         next_steer_cnt = sw.steer_dly;
      end
      else if (steer_pend)
      begin
         if (steer_cnt == 5'h00)
         begin
            next_steer_pend = 1'b0;
            next_steer_sel = !steer_sel;
         end
         else
            next_steer_cnt = 5'(steer_cnt - 5'h01);
      end
   end

   // Registers of the sequencer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= TSD_IDLE;
         ovl_cnt <= 7'h00;
         ovl_len <= 7'h00;
         steer_pend <= 1'b0;
         steer_cnt <= 5'h00;
         steer_sel <= 1'b0;
      end
      else
      begin
         state <= next_state;
         ovl_cnt <= next_ovl_cnt;
         ovl_len <= next_ovl_len;
         steer_pend <= next_steer_pend;
         steer_cnt <= next_steer_cnt;
         steer_sel <= next_steer_sel;
      end
   end

   assign sw.overlap_active = (state == TSD_OVERLAP);
   assign sw.steer_sel = steer_sel;
   assign sw.busy = (state != TSD_IDLE) || steer_pend;

   ////////////////////////////////////////////////////////////////////////
   // Helper: length of the current overlap run
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         run_cnt <= 7'h00;
      else if (sw.overlap_active)
         run_cnt <= 7'(run_cnt + 7'h01);
      else
         run_cnt <= 7'h00;
   end

   overlap_len_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      $fell(sw.overlap_active) |-> run_cnt == ovl_len)
      else $error("overlap window length wrong");

   overlap_start_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      start_ok |=> sw.overlap_active
         && ovl_len == 7'(OVL_BASE_CYC + {1'b0, $past(sw.ovl_dly), 1'b0}))
      else $error("overlap did not start with programmed length");

   steer_only_swap_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      $changed(steer_sel) |-> $past(steer_pend) && $past(steer_cnt) == 5'h00)
      else $error("steering select moved outside its delayed swap slot");

endmodule : tsd_swap_timer

// ===== logic/tsd_regs.sv
// Trim and swap delay register bank with APB slave and swap sequencer.
// Assumes fuse data, calibration enable and swap requests are synchronous
// to pclk; the fuse storage raises fuse_valid once its codes are stable.
//
// Function
// - Four 8-bit read/write per-channel termination trims
// - Trims load fuse values after reset, writable
// - Overlap lasts four plus twice delay cycles
// - Overlap delay field bits 4:0, resets to 8
// - Steering delay field bits 4:0, resets to 7
// - Steering delay applies to select, swaps only
`timescale 1ns/100ps
module tsd_regs
   import tsd_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic fuse_valid,
   input wire logic [3:0][7:0] fuse_trim_codes,
   input wire logic cal_en,
   input wire logic swap_start,
   output logic [3:0][7:0] term_trim_codes,
   output logic overlap_active,
   output logic steer_sel
);

   ////////////////////////////////////////////////////////////////////////
   // Address decoding helpers
   function automatic logic [7:0] reg_index(input logic [11:0] addr);
      reg_index = addr[9:2];
   endfunction : reg_index

   function automatic logic is_mapped(input logic [11:0] addr);
      logic [7:0] idx;
      idx = addr[9:2];
      is_mapped = (addr[11:10] == 2'b00) && (addr[1:0] == 2'b00)
         && ((idx >= IDX_TRIM_A && idx <= IDX_TRIM_D)
            || idx == IDX_OVL_DLY || idx == IDX_STEER_DLY
            || idx == IDX_STATUS);
   endfunction : is_mapped

   logic wr_en;
   logic rd_setup;
   logic [7:0] wr_idx;
   logic fuse_pend;
   logic next_fuse_pend;
   logic fuse_load;
   logic [4:0] ovl_dly;
   logic [4:0] next_ovl_dly;
   logic [4:0] steer_dly;
   logic [4:0] next_steer_dly;
   logic cal_wr_flag;
   logic next_cal_wr_flag;
   logic [31:0] next_prdata;
   logic [31:0] status_word;
   logic [7:0] trim [NUM_CH];
   logic [7:0] next_trim [NUM_CH];
   logic boot;

   tsd_swap_if sw ();

   ////////////////////////////////////////////////////////////////////////
   // APB strobes; zero wait states, read data staged in the setup cycle
   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite && is_mapped(paddr);
   assign rd_setup = psel && !penable && !pwrite;
   assign wr_idx = reg_index(paddr);
   // Unmapped or misaligned accesses answer with an error, nothing changes
   assign pslverr = psel && penable && !is_mapped(paddr);

   ////////////////////////////////////////////////////////////////////////
   // Fuse load: one shot after reset, in the first cycle that fuse_valid is seen
   assign fuse_load = fuse_pend && fuse_valid;

   always_comb
   begin
      next_fuse_pend = fuse_pend;
      if (fuse_load)
         next_fuse_pend = 1'b0;
   end

   // Pending flag set by reset, not by the fuse port, as reset takes constants
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fuse_pend <= 1'b1;
      else
         fuse_pend <= next_fuse_pend;
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-channel termination trims
   generate
      for (genvar ch = 0; ch < NUM_CH; ch++)
      begin : g_trim
         localparam logic [7:0] CH_IDX = 8'(IDX_TRIM_A + 8'(ch));

         // Fuse load takes priority so a write in that cycle is dropped
         always_comb
         begin
            next_trim[ch] = trim[ch];
            if (fuse_load)
               next_trim[ch] = fuse_trim_codes[ch];
            else if (wr_en && wr_idx == CH_IDX)
               next_trim[ch] = pwdata[7:0];
         end

         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               trim[ch] <= TRIM_RESET;
            else
               trim[ch] <= next_trim[ch];
         end

         assign term_trim_codes[ch] = trim[ch];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Swap delay fields and the calibration-write status flag
   always_comb
   begin
      next_ovl_dly = ovl_dly;
      next_steer_dly = steer_dly;
      next_cal_wr_flag = cal_wr_flag;
      // Clear first so a new event in the same cycle still sets it
      if (wr_en && wr_idx == IDX_STATUS && pwdata[ST_CAL_WR])
         next_cal_wr_flag = 1'b0;
      if (wr_en && wr_idx == IDX_OVL_DLY)
      begin
         next_ovl_dly = pwdata[4:0];
         if (cal_en)
            next_cal_wr_flag = 1'b1;
      end
      // Reserved bits 7:5 are not stored and read back as zero
      if (wr_en && wr_idx == IDX_STEER_DLY)
         next_steer_dly = pwdata[4:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ovl_dly <= OVL_RESET;
         steer_dly <= STEER_RESET;
         cal_wr_flag <= 1'b0;
      end
      else
      begin
         ovl_dly <= next_ovl_dly;
         steer_dly <= next_steer_dly;
         cal_wr_flag <= next_cal_wr_flag;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data, registered in the setup cycle
   always_comb
   begin
      status_word = 32'h0000_0000;
      status_word[ST_OVERLAP] = sw.overlap_active;
      status_word[ST_STEER] = sw.steer_sel;
      status_word[ST_BUSY] = sw.busy;
      status_word[ST_CAL_WR] = cal_wr_flag;
      status_word[ST_FUSE_PEND] = fuse_pend;
   end

   always_comb
   begin
      next_prdata = prdata;
      if (rd_setup)
      begin
         next_prdata = 32'h0000_0000;
         if (is_mapped(paddr))
         begin
            case (reg_index(paddr))
               IDX_TRIM_A: next_prdata[7:0] = trim[0];
               IDX_TRIM_B: next_prdata[7:0] = trim[1];
               IDX_TRIM_C: next_prdata[7:0] = trim[2];
               IDX_TRIM_D: next_prdata[7:0] = trim[3];
               IDX_OVL_DLY: next_prdata[4:0] = ovl_dly;
               IDX_STEER_DLY: next_prdata[4:0] = steer_dly;
               IDX_STATUS: next_prdata = status_word;
               default: next_prdata = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else
         prdata <= next_prdata;
   end

   ////////////////////////////////////////////////////////////////////////
   // Swap sequencer; swaps only start with calibration enabled
   assign sw.swap_start = swap_start && cal_en;
   assign sw.ovl_dly = ovl_dly;
   assign sw.steer_dly = steer_dly;

   tsd_swap_timer u_swap (
      .pclk(pclk),
      .presetn(presetn),
      .sw(sw)
   );

   assign overlap_active = sw.overlap_active;
   assign steer_sel = sw.steer_sel;

   ////////////////////////////////////////////////////////////////////////
   // Helper: marks the first clock after reset release
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         boot <= 1'b1;
      else
         boot <= 1'b0;
   end

   delay_reset_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      boot |-> ovl_dly == OVL_RESET && steer_dly == STEER_RESET)
      else $error("delay fields not at reset values");

   fuse_load_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      fuse_load |=> term_trim_codes == $past(fuse_trim_codes) && !fuse_pend)
      else $error("trims did not take fuse codes");

   trim_write_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      (wr_en && !fuse_load && wr_idx == IDX_TRIM_C)
         |=> term_trim_codes[2] == $past(pwdata[7:0]))
      else $error("trim write lost");

   delay_read_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      (rd_setup && paddr == {2'b00, IDX_STEER_DLY, 2'b00})
         ##1 (psel && penable) |-> prdata == {27'h000_0000, steer_dly})
      else $error("steering delay read wrong");

   cal_flag_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      (wr_en && wr_idx == IDX_OVL_DLY && cal_en) |=> cal_wr_flag)
      else $error("overlap write under calibration not flagged");

   ////////////////////////////////////////////////////////////////////////
   // Refused accesses must leave every register alone, fuse load aside
   err_no_write_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      (psel && penable && !is_mapped(paddr) && !fuse_load)
         |=> $stable(term_trim_codes) && $stable(ovl_dly)
            && $stable(steer_dly))
      else $error("refused access changed a register");

   pslverr_align_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      (psel && penable && paddr[1:0] != 2'b00) |-> pslverr)
      else $error("misaligned access not refused");

   trim_read_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      (rd_setup && paddr == {2'b00, IDX_TRIM_A, 2'b00})
         |=> prdata == {24'h00_0000, $past(term_trim_codes[0])})
      else $error("trim read wrong");

   // Guards against the trims changing without a fuse load or a register write
   trim_hold_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      (!fuse_load && !wr_en) |=> $stable(term_trim_codes))
      else $error("trims changed without load or write");

   ovl_write_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      (wr_en && wr_idx == IDX_OVL_DLY) |=> ovl_dly == $past(pwdata[4:0]))
      else $error("overlap delay write lost");

   ovl_read_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      (rd_setup && paddr == {2'b00, IDX_OVL_DLY, 2'b00})
         |=> prdata == {27'h000_0000, $past(ovl_dly)})
      else $error("overlap delay read wrong");

   steer_write_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      (wr_en && wr_idx == IDX_STEER_DLY) |=> steer_dly == $past(pwdata[4:0]))
      else $error("steering delay write lost");

   // Swaps open only from idle and only with calibration on
   swap_start_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      (swap_start && cal_en && !sw.busy) |=> overlap_active)
      else $error("accepted swap request did not open overlap");

   no_cal_swap_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      (!cal_en && !sw.busy) |=> !overlap_active)
      else $error("overlap opened with calibration off");

endmodule : tsd_regs

// ===== verif/tb_trim_and_swap_delay_regs.sv
// Self-checking bench for the trim and swap delay register bank.
// Assumes the bank answers APB with zero wait states; no partner model.
`timescale 1ns/100ps
module tb_trim_and_swap_delay_regs
   import tsd_pkg::*;
   ();
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, pready, pslverr;
   logic fuse_valid, cal_en, swap_start, overlap_active, steer_sel;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0][7:0] fuse_trim_codes, term_trim_codes, fz;
   logic [33:0] bus_q[$];
   logic [33:0] b;
   logic [6:0] ovl_q[$], st_q[$];
   logic [6:0] ocnt, scnt;
   logic last_steer;
   logic [7:0] v;
   logic [4:0] dly [4] = '{5'h00, 5'h1F, 5'h00, 5'h0C};
   int error_cnt = 0;
   int num_checks = 0;
   int cyc = 0;

   ////////////////////////////////////////////////////////////////////////
   // Clock and device
   always #2 pclk = ~pclk;
   tsd_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fuse_valid(fuse_valid), .fuse_trim_codes(fuse_trim_codes),
      .cal_en(cal_en), .swap_start(swap_start),
      .term_trim_codes(term_trim_codes), .overlap_active(overlap_active),
      .steer_sel(steer_sel));

   ////////////////////////////////////////////////////////////////////////
   // Shared tasks
   function automatic logic [11:0] adr(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction : adr

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] s);
      num_checks++;
      if (s !== e)
      begin
         error_cnt++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask : chk

   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : close_out

   // Hold the request until pready is seen; note the expected answer
   task automatic xfer(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic err,
                       input logic [31:0] ed);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      bus_q.push_back({wr, err, ed});
      @(posedge pclk);
      penable <= 1'b1;
      // Only the hang guard ends a wait that never sees pready
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      xfer(1'b1, adr(idx), d, 1'b0, 32'h0000_0000);
   endtask : wr

   task automatic rd(input logic [7:0] idx, input logic [31:0] e);
      xfer(1'b0, adr(idx), 32'h0000_0000, 1'b0, e);
   endtask : rd

   task automatic reset_dut();
      presetn <= 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
   endtask : reset_dut

   // Delays are only ever changed with calibration off, upper bits zero
   task automatic swap_go(input logic [4:0] o, input logic [4:0] s);
      @(posedge pclk);
      cal_en <= 1'b1;
      swap_start <= 1'b1;
      ovl_q.push_back(7'h04 + {1'b0, o, 1'b0});
      st_q.push_back({2'b00, s} + 7'h02);
      @(posedge pclk);
      swap_start <= 1'b0;
      // A swap that never ends is left to the hang guard
      while (ovl_q.size() != 0 || st_q.size() != 0)
      begin
         @(posedge pclk);
      end
      @(posedge pclk);
      cal_en <= 1'b0;
   endtask : swap_go

   ////////////////////////////////////////////////////////////////////////
   // Bus monitor: takes the oldest note at each completed access
   always @(posedge pclk)
   begin
      if (presetn === 1'b1 && psel === 1'b1 && penable === 1'b1 &&
          pready === 1'b1)
      begin
         b = bus_q.pop_front();
         chk("pslverr", {31'h0, b[32]}, {31'h0, pslverr});
         if (!b[33])
            chk("prdata", b[31:0], prdata);
      end
   end

   // Swap monitor: overlap length and cycles from start to select change
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ocnt = 7'h00;
         scnt = 7'h00;
         last_steer = 1'b0;
      end
      else
      begin
         scnt = scnt + 7'h01;
         if (swap_start === 1'b1 && cal_en === 1'b1)
            scnt = 7'h00;
         if (overlap_active === 1'b1)
            ocnt = ocnt + 7'h01;
         else if (ocnt != 7'h00)
         begin
            if (ovl_q.size() == 0)
            begin
               error_cnt++;
               $display("BAD overlap_len exp none seen %0d", ocnt);
            end
            else
               chk("overlap_len", {25'h0, ovl_q.pop_front()}, {25'h0, ocnt});
            ocnt = 7'h00;
         end
         if (steer_sel !== last_steer)
         begin
            if (st_q.size() == 0)
            begin
               error_cnt++;
               $display("BAD steer_delay exp none seen %0d", scnt);
            end
            else
               chk("steer_delay", {25'h0, st_q.pop_front()}, {25'h0, scnt});
            last_steer = steer_sel;
         end
      end
   end

   // Hang guard, a run needs well under 5000 cycles
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         close_out();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      fuse_valid = 1'b0;
      cal_en = 1'b0;
      swap_start = 1'b0;
      void'($urandom(32'h05bf));
      fuse_trim_codes = $urandom;
      dly[2] = 5'($urandom);
      reset_dut();
      for (int i = 0; i < 4; i++)
         rd(IDX_TRIM_A + 8'(i), 32'h0000_0000);
      rd(IDX_OVL_DLY, 32'h0000_0008);
      rd(IDX_STEER_DLY, 32'h0000_0007);
      // Status shows the fuse load still pending, nothing else
      rd(IDX_STATUS, 32'h0000_0010);
      // Fuse codes taken once; a later change must not reload
      @(posedge pclk);
      fuse_valid <= 1'b1;
      fz = fuse_trim_codes;
      @(posedge pclk);
      fuse_trim_codes <= ~fz;
      for (int i = 0; i < 4; i++)
      begin
         rd(IDX_TRIM_A + 8'(i), {24'h0, fz[i]});
         chk("term_trim", {24'h0, fz[i]}, 32'(term_trim_codes[i]));
      end
      rd(IDX_STATUS, 32'h0000_0000);
      // Software overwrite of every channel
      for (int i = 0; i < 4; i++)
      begin
         v = 8'($urandom);
         fz[i] = v;
         wr(IDX_TRIM_A + 8'(i), {24'h0, v});
         rd(IDX_TRIM_A + 8'(i), {24'h0, v});
         chk("term_trim", {24'h0, v}, {24'h0, term_trim_codes[i]});
      end
      // Unmapped, misaligned and out-of-range accesses are refused
      xfer(1'b0, 12'h300, 32'h0000_0000, 1'b1, 32'h0000_0000);
      xfer(1'b1, 12'h1F9, 32'h0000_00FF, 1'b1, 32'h0000_0000);
      xfer(1'b1, 12'h5F8, 32'h0000_00FF, 1'b1, 32'h0000_0000);
      rd(IDX_TRIM_A, {24'h0, fz[0]});
      // Both delay fields over their range, then swaps with them
      for (int i = 0; i < 4; i++)
      begin
         wr(IDX_OVL_DLY, {27'h0, dly[i]});
         rd(IDX_OVL_DLY, {27'h0, dly[i]});
         wr(IDX_STEER_DLY, {27'h0, dly[3 - i]});
         rd(IDX_STEER_DLY, {27'h0, dly[3 - i]});
         swap_go(dly[i], dly[3 - i]);
      end
      // A request with calibration off must not start a swap
      @(posedge pclk);
      swap_start <= 1'b1;
      @(posedge pclk);
      swap_start <= 1'b0;
      // Look while a wrongly started overlap would still stand
      repeat (2) @(posedge pclk);
      chk("overlap_active", 32'h0, {31'h0, overlap_active});
      repeat (40) @(posedge pclk);
      // Second reset mid-run: defaults back, fuse codes reloaded
      fz = fuse_trim_codes;
      reset_dut();
      rd(IDX_OVL_DLY, 32'h0000_0008);
      rd(IDX_STEER_DLY, 32'h0000_0007);
      for (int i = 0; i < 4; i++)
         rd(IDX_TRIM_A + 8'(i), {24'h0, fz[i]});
      swap_go(5'h08, 5'h07);
      close_out();
   end
endmodule : tb_trim_and_swap_delay_regs
